//--- core/bus_cond_detect.v
// Start, stop and clock edge detector on synchronised bus lines
`default_nettype none
module bus_cond_detect (
	input wire sys_clk,
	input wire nrst,
	input wire scl,
	input wire sda,
	output wire start_seen,
	output wire stop_seen,
	output wire scl_rise,
	output wire scl_fall
);
	reg scl_d_reg;
	reg sda_d_reg;
	// Previous line levels
	always @(posedge sys_clk) begin
		if (!nrst) begin
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end else begin
			scl_d_reg <= scl;
			sda_d_reg <= sda;
		end
	end
	// Data edges while the clock stays high
	assign start_seen = scl_d_reg & scl & sda_d_reg & ~sda; // RULE17
	assign stop_seen = scl_d_reg & scl & ~sda_d_reg & sda; // RULE17
	assign scl_rise = ~scl_d_reg & scl;
	assign scl_fall = scl_d_reg & ~scl;
endmodule // bus_cond_detect
`default_nettype wire

//--- core/i2c_fw_master.v
// Serial port two-wire support: conditions, slave byte engine, registers
//
// Contract
// RULE1: Reset or disable clears start and stop flags
// RULE2: Latest condition flag set, other one cleared
// RULE3: Firmware claims bus on stop or idle
// RULE4: Cleared direction bit drives line low always
// RULE5: Firmware sends data by toggling data direction
// RULE6: Firmware clocks by toggling clock direction
// RULE7: Interrupt flag on start, stop, each byte
// RULE8: Mode 1011 master support, slave idle
// RULE9: Firmware sorts shared interrupt sources itself
// RULE10: Busy bus interrupt raised at ending stop
// RULE11: Firmware releases lines on lost arbitration
// RULE12: Firmware retransmits data lost in arbitration
// RULE13: Slave keeps receiving and acknowledges own address
// RULE14: Software keeps phase and edge bits clear
// RULE15: Two-wire mode with enable makes pins open-drain
// RULE16: Byte flag set on ninth clock falling edge
// RULE17: Start is data fall, stop data rise, clock high
//
// Strobed register access is this design's own decision.
`include "i2c_fw_master_map.vh"
`default_nettype none
module i2c_fw_master (
	input wire sys_clk,
	input wire nrst,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	input wire scl_in,
	input wire sda_in,
	output wire scl_out,
	output wire sda_out,
	output wire scl_oe_n,
	output wire sda_oe_n,
	output wire irq
);
	////////////////////////////////////////////////////////////////////////
	// Registers
	reg [7:0] core_interrupt_control_reg;
	reg [7:0] pir_reg;
	reg [7:0] pie_reg;
	reg [7:0] buf_reg;
	reg [7:0] ctl_reg;
	reg [7:0] dir_reg;
	reg [7:0] latch_reg;
	reg [7:0] own_reg;
	reg [7:0] sta_reg;
	reg [7:0] ev_reg;
	reg [7:0] ev_mask_reg;
	reg [7:0] shift_reg;
	reg [3:0] bit_cnt_reg;
	reg active_reg;
	reg addressed_reg;
	reg addr_phase_reg;
	reg transmit_reg;
	reg ack_drive_reg;
	reg hold_scl_reg;
	reg tx_bit_reg;
	reg tx_en_reg;
	wire scl;
	wire sda;
	wire cond_start;
	wire cond_stop;
	wire scl_rise;
	wire scl_fall;
	wire [3:0] mode;
	wire en;
	wire i2c_mode;
	wire slave_on;
	wire cond_irq_on;
	wire addr_match;
	wire rx_ok;
	wire wr_hit_ctl;
	wire wr_hit_pir;
	wire rd_hit_buf;
	wire rd_hit_ev;
	wire byte_done;
	wire drive_scl_low;
	wire drive_sda_low;
	reg set_if;
	reg [7:0] ev_set;

	// Address compare helper used by the register decode
	function hit;
		input [7:0] a;
		input [7:0] b;
		input s;
		begin
			hit = s && (a == b);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisation and condition detection
	pin_sync #(.WIDTH(2)) u_sync (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.pin_in({scl_in, sda_in}),
		.pin_out({scl, sda})
	);

	bus_cond_detect u_det (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.scl(scl),
		.sda(sda),
		.start_seen(cond_start),
		.stop_seen(cond_stop),
		.scl_rise(scl_rise),
		.scl_fall(scl_fall)
	);

	////////////////////////////////////////////////////////////////////////
	// Mode decode
	assign mode = ctl_reg[`CTL_MODE_HI:`CTL_MODE_LO];
	assign en = ctl_reg[`CTL_EN];
	assign slave_on = en && (mode == `MODE_SLAVE7 || mode == `MODE_SLAVE10 ||
		mode == `MODE_SLAVE7_SP || mode == `MODE_SLAVE10_SP); // RULE13
	assign cond_irq_on = en && (mode == `MODE_MASTER_FW ||
		mode == `MODE_SLAVE7_SP || mode == `MODE_SLAVE10_SP); // RULE8
	assign i2c_mode = slave_on || cond_irq_on;
	assign addr_match = (shift_reg[7:1] == own_reg[7:1]);
	assign rx_ok = !sta_reg[`STA_BF] && !ctl_reg[`CTL_RECEIVE_OVERFLOW_FLAG];
	assign byte_done = scl_fall && (bit_cnt_reg == `ACK_CLOCK) &&
		(active_reg || cond_irq_on); // RULE16
	assign wr_hit_ctl = hit(reg_addr, `ADDR_SERIAL_PORT_CONTROL, reg_wr);
	assign wr_hit_pir = hit(reg_addr, `ADDR_PERIPHERAL_FLAGS_ONE, reg_wr);
	assign rd_hit_buf = hit(reg_addr, `ADDR_SERIAL_SHIFT_BUFFER, reg_rd);
	assign rd_hit_ev = hit(reg_addr, `ADDR_EVENT_STATUS, reg_rd);

	////////////////////////////////////////////////////////////////////////
	// Pin drive: open drain, low only, enable active low
	assign drive_scl_low = !dir_reg[`PIN_SCL] ||
		(i2c_mode && hold_scl_reg); // RULE4
	assign drive_sda_low = !dir_reg[`PIN_SDA] ||
		(i2c_mode && (ack_drive_reg || (tx_en_reg && !tx_bit_reg))); // RULE4
	assign scl_out = 1'b0; // RULE15
	assign sda_out = 1'b0; // RULE15
	assign scl_oe_n = !drive_scl_low;
	assign sda_oe_n = !drive_sda_low;

	////////////////////////////////////////////////////////////////////////
	// Event sources this cycle
	always @* begin
		set_if = 1'b0;
		ev_set = 8'h00;
		if (cond_irq_on && cond_start) begin
			set_if = 1'b1; // RULE7
			ev_set[`EV_START] = 1'b1;
		end
		if (cond_irq_on && cond_stop) begin
			set_if = 1'b1; // RULE10
			ev_set[`EV_STOP] = 1'b1;
		end
		if (byte_done && (cond_irq_on || addressed_reg || addr_phase_reg)) begin
			if (cond_irq_on || addressed_reg) begin
				set_if = 1'b1; // RULE7
				ev_set[`EV_BYTE] = 1'b1;
			end
		end
		if (ack_drive_reg && scl_fall)
			ev_set[`EV_ACK] = 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// Slave byte engine and status flags
	always @(posedge sys_clk) begin
		if (!nrst || !en) begin
			sta_reg <= `RST_BYTE; // RULE1
			shift_reg <= `RST_BYTE;
			bit_cnt_reg <= 4'h0;
			active_reg <= 1'b0;
			addressed_reg <= 1'b0;
			addr_phase_reg <= 1'b0;
			transmit_reg <= 1'b0;
			ack_drive_reg <= 1'b0;
			hold_scl_reg <= 1'b0;
			tx_bit_reg <= 1'b1;
			tx_en_reg <= 1'b0;
		end else begin
			if (reg_wr && reg_addr == `ADDR_SERIAL_PORT_STATUS) begin
				sta_reg[`STA_SMP] <= reg_wdata[`STA_SMP];
				sta_reg[`STA_CKE] <= reg_wdata[`STA_CKE];
			end
			if (rd_hit_buf)
				sta_reg[`STA_BF] <= 1'b0;
			if (wr_hit_ctl && reg_wdata[`CTL_CKP])
				hold_scl_reg <= 1'b0;
			if (reg_wr && reg_addr == `ADDR_SERIAL_SHIFT_BUFFER) begin
				shift_reg <= reg_wdata;
				tx_en_reg <= transmit_reg;
			end
			if (cond_start) begin
				sta_reg[`STA_START] <= 1'b1; // RULE2
				sta_reg[`STA_STOP] <= 1'b0; // RULE2
				active_reg <= 1'b1;
				addr_phase_reg <= 1'b1;
				addressed_reg <= 1'b0;
				bit_cnt_reg <= 4'h0;
				ack_drive_reg <= 1'b0;
				tx_en_reg <= 1'b0;
			end else if (cond_stop) begin
				sta_reg[`STA_STOP] <= 1'b1; // RULE2
				sta_reg[`STA_START] <= 1'b0; // RULE2
				active_reg <= 1'b0;
				addressed_reg <= 1'b0;
				addr_phase_reg <= 1'b0;
				ack_drive_reg <= 1'b0;
				tx_en_reg <= 1'b0;
				hold_scl_reg <= 1'b0;
			end else if (active_reg && scl_rise) begin
				// Sample data on rising clock, count clocks
				if (bit_cnt_reg < `BITS_PER_BYTE && !tx_en_reg)
					shift_reg <= {shift_reg[6:0], sda};
				if (bit_cnt_reg == `ACK_CLOCK - 4'h1 && transmit_reg && sda)
					transmit_reg <= 1'b0;
				bit_cnt_reg <= bit_cnt_reg + 4'h1;
			end else if (active_reg && scl_fall) begin
				if (bit_cnt_reg == `BITS_PER_BYTE && slave_on) begin
					// Address or data byte complete; slave keeps going
					if (addr_phase_reg && addr_match && rx_ok) begin
						ack_drive_reg <= 1'b1; // RULE13
						addressed_reg <= 1'b1;
						buf_reg <= shift_reg;
						sta_reg[`STA_BF] <= 1'b1;
						sta_reg[`STA_RW] <= shift_reg[0];
						sta_reg[`STA_DA] <= 1'b0;
						transmit_reg <= shift_reg[0];
					end else if (!addr_phase_reg && addressed_reg &&
						!transmit_reg) begin
						if (rx_ok) begin
							ack_drive_reg <= 1'b1;
							buf_reg <= shift_reg;
							sta_reg[`STA_BF] <= 1'b1;
							sta_reg[`STA_DA] <= 1'b1;
						end
					end
					tx_en_reg <= 1'b0;
				end
				if (bit_cnt_reg == `ACK_CLOCK) begin
					ack_drive_reg <= 1'b0;
					addr_phase_reg <= 1'b0;
					bit_cnt_reg <= 4'h0;
					if (transmit_reg && addressed_reg)
						hold_scl_reg <= 1'b1;
				end
				if (tx_en_reg && bit_cnt_reg < `BITS_PER_BYTE)
					tx_bit_reg <= shift_reg[3'h7 - bit_cnt_reg[2:0]];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Software registers and sticky flags (set wins over clear)
	always @(posedge sys_clk) begin
		if (!nrst) begin
			core_interrupt_control_reg <= `RST_BYTE;
			pir_reg <= `RST_BYTE;
			pie_reg <= `RST_BYTE;
			ctl_reg <= `RST_BYTE;
			dir_reg <= `RST_PORT_B_DIRECTION;
			latch_reg <= `RST_BYTE;
			own_reg <= `RST_BYTE;
			ev_reg <= `RST_BYTE;
			ev_mask_reg <= `RST_BYTE;
		end else begin
			if (hit(reg_addr, `ADDR_CORE_INTERRUPT_CONTROL, reg_wr))
				core_interrupt_control_reg <= reg_wdata;
			if (hit(reg_addr, `ADDR_PERIPHERAL_ENABLES_ONE, reg_wr))
				pie_reg <= reg_wdata;
			if (hit(reg_addr, `ADDR_PORT_B_DIRECTION, reg_wr))
				dir_reg <= reg_wdata;
			if (hit(reg_addr, `ADDR_PORT_B_LATCH, reg_wr))
				latch_reg <= reg_wdata;
			if (hit(reg_addr, `ADDR_SERIAL_OWN_ADDRESS, reg_wr))
				own_reg <= reg_wdata;
			if (hit(reg_addr, `ADDR_EVENT_MASK, reg_wr))
				ev_mask_reg <= reg_wdata;
			if (wr_hit_ctl)
				ctl_reg <= reg_wdata;
			if (wr_hit_pir)
				pir_reg <= reg_wdata;
			if (set_if)
				pir_reg[`PIR_SERIAL] <= 1'b1; // RULE7
			if (rd_hit_ev)
				ev_reg <= ev_set;
			else
				ev_reg <= ev_reg | ev_set;
		end
	end

	// Level interrupt: flag path or masked sticky events
	assign irq = (pir_reg[`PIR_SERIAL] && pie_reg[`PIR_SERIAL] &&
		core_interrupt_control_reg[`CORE_INTERRUPT_CONTROL_PEIE] && core_interrupt_control_reg[`CORE_INTERRUPT_CONTROL_GIE]) ||
		|(ev_reg & ev_mask_reg); // RULE10

	////////////////////////////////////////////////////////////////////////
	// Read data, one cycle after the strobe
	always @(posedge sys_clk) begin
		if (!nrst) begin
			reg_rdata <= `RST_BYTE;
		end else if (reg_rd) begin
			case (reg_addr)
			`ADDR_CORE_INTERRUPT_CONTROL: reg_rdata <= core_interrupt_control_reg;
			`ADDR_PERIPHERAL_FLAGS_ONE: reg_rdata <= pir_reg;
			`ADDR_SERIAL_SHIFT_BUFFER: reg_rdata <= buf_reg;
			`ADDR_SERIAL_PORT_CONTROL: reg_rdata <= ctl_reg;
			`ADDR_PORT_B_DIRECTION: reg_rdata <= dir_reg;
			`ADDR_PORT_B_LATCH: reg_rdata <= latch_reg;
			`ADDR_PERIPHERAL_ENABLES_ONE: reg_rdata <= pie_reg;
			`ADDR_SERIAL_OWN_ADDRESS: reg_rdata <= own_reg;
			`ADDR_SERIAL_PORT_STATUS: reg_rdata <= sta_reg;
			`ADDR_EVENT_STATUS: reg_rdata <= ev_reg;
			`ADDR_EVENT_MASK: reg_rdata <= ev_mask_reg;
			default: reg_rdata <= `RST_BYTE;
			endcase
		end else begin
			reg_rdata <= `RST_BYTE;
		end
	end
endmodule // i2c_fw_master
`default_nettype wire

//--- core/i2c_fw_master_map.vh
// Register offsets, field positions, reset values and mode codes
`ifndef I2C_FW_MASTER_MAP_VH
`define I2C_FW_MASTER_MAP_VH
`define ADDR_CORE_INTERRUPT_CONTROL 8'h0b
`define ADDR_PERIPHERAL_FLAGS_ONE 8'h0c
`define ADDR_SERIAL_SHIFT_BUFFER 8'h13
`define ADDR_SERIAL_PORT_CONTROL 8'h14
`define ADDR_PORT_B_DIRECTION 8'h86
`define ADDR_PERIPHERAL_ENABLES_ONE 8'h8c
`define ADDR_SERIAL_OWN_ADDRESS 8'h93
`define ADDR_SERIAL_PORT_STATUS 8'h94
`define ADDR_PORT_B_LATCH 8'h06
`define ADDR_EVENT_STATUS 8'h40
`define ADDR_EVENT_MASK 8'h41
`define RST_PORT_B_DIRECTION 8'hff
`define RST_BYTE 8'h00
// Control register fields
`define CTL_WRITE_COLLISION_FLAG 7
`define CTL_RECEIVE_OVERFLOW_FLAG 6
`define CTL_EN 5
`define CTL_CKP 4
`define CTL_MODE_HI 3
`define CTL_MODE_LO 0
// Status register fields
`define STA_SMP 7
`define STA_CKE 6
`define STA_DA 5
`define STA_STOP 4
`define STA_START 3
`define STA_RW 2
`define STA_UA 1
`define STA_BF 0
// Flag and enable positions
`define PIR_SERIAL 3
`define CORE_INTERRUPT_CONTROL_GIE 7
`define CORE_INTERRUPT_CONTROL_PEIE 6
// Pins on port b
`define PIN_SCL 4
`define PIN_SDA 1
// Mode codes
`define MODE_SLAVE7 4'h6
`define MODE_SLAVE10 4'h7
`define MODE_MASTER_FW 4'hb
`define MODE_SLAVE7_SP 4'he
`define MODE_SLAVE10_SP 4'hf
// Event status bits
`define EV_START 0
`define EV_STOP 1
`define EV_BYTE 2
`define EV_ACK 3
`define BITS_PER_BYTE 4'h8
`define ACK_CLOCK 4'h9
`endif

//--- core/pin_sync.v
// Two-stage synchroniser for a bundle of pin inputs
`default_nettype none
module pin_sync #(
	parameter WIDTH = 2
) (
	input wire sys_clk,
	input wire nrst,
	input wire [WIDTH-1:0] pin_in,
	output wire [WIDTH-1:0] pin_out
);
	reg [WIDTH-1:0] meta_reg;
	reg [WIDTH-1:0] sync_reg;
	// First stage read only by the second; lines idle high
	always @(posedge sys_clk) begin
		if (!nrst) begin
			meta_reg <= {WIDTH{1'b1}};
			sync_reg <= {WIDTH{1'b1}};
		end else begin
			meta_reg <= pin_in;
			sync_reg <= meta_reg;
		end
	end
	assign pin_out = sync_reg;
endmodule // pin_sync
`default_nettype wire

//--- sim/i2c_bus_partner.sv
// Second bus master that frames starts, bytes and stops
`default_nettype none
module i2c_bus_partner (
	input wire logic sda_line,
	output logic scl_pull,
	output logic sda_pull
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam realtime QTR = 31.25;
	// Both lines released, clock stands still outside frames
	initial begin
		scl_pull = 1'b0;
		sda_pull = 1'b0;
	end
	// Claims the bus without checking that it is idle: data falls while clock is high
	task automatic start();
		sda_pull = 1'b1;
		#QTR scl_pull = 1'b1;
		#QTR;
	endtask
	// Eight bits MSB first, the ninth clock samples acknowledge
	task automatic send(input logic [7:0] b, output logic ack);
		for (int i = 0; i < 9; i++) begin
			sda_pull = (i < 8) ? ~b[7-i] : 1'b0;
			#QTR scl_pull = 1'b0;
			#QTR ack = sda_line;
			#QTR scl_pull = 1'b1;
			#QTR;
		end
	endtask
	// Data rises while clock is high
	task automatic stop();
		sda_pull = 1'b1;
		#QTR scl_pull = 1'b0;
		#QTR sda_pull = 1'b0;
		#QTR;
	endtask
endmodule // i2c_bus_partner
`default_nettype wire

//--- sim/i2c_fw_master_properties.sv
// Checker of the register port, pin drive and condition interrupts
`default_nettype none
module i2c_fw_master_chk (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic scl_out,
	input wire logic sda_out,
	input wire logic scl_oe_n,
	input wire logic sda_oe_n,
	input wire logic irq
);
	logic [7:0] mask_reg;
	logic en_reg;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	// Shadow of event mask and of port enable in mode 1011
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			mask_reg <= 8'h00;
			en_reg <= 1'b0;
		end else if (reg_wr) begin
			if (reg_addr == 8'h41) mask_reg <= reg_wdata;
			if (reg_addr == 8'h14)
				en_reg <= reg_wdata[5] && reg_wdata[3:0] == 4'hb;
		end
	end
	////////////////////////////////////////////////////////////////////////
	property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data outside its slot");
	property p_unmapped; reg_rd && reg_addr == 8'h55 |=> reg_rdata == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");
	property p_out_low; scl_out == 1'b0 && sda_out == 1'b0; endproperty
	a_out_low: assert property (p_out_low)
		else $error("pin output level not low");
	property p_scl_dir; reg_wr && reg_addr == 8'h86
		|=> scl_oe_n == $past(reg_wdata[4]); endproperty
	a_scl_dir: assert property (p_scl_dir)
		else $error("clock drive does not follow direction");
	property p_sda_dir; reg_wr && reg_addr == 8'h86
		|=> sda_oe_n == $past(reg_wdata[1]); endproperty
	a_sda_dir: assert property (p_sda_dir)
		else $error("data drive does not follow direction");
	property p_oe_rst; $rose(nrst) |-> scl_oe_n && sda_oe_n; endproperty
	a_oe_rst: assert property (p_oe_rst)
		else $error("lines driven after reset");
	property p_irq_rst; $rose(nrst) |-> !irq; endproperty
	a_irq_rst: assert property (p_irq_rst)
		else $error("interrupt high after reset");
	property p_start_irq; en_reg && mask_reg[0] && scl_in && $fell(sda_in)
		|-> ##[2:8] irq; endproperty
	a_start_irq: assert property (p_start_irq)
		else $error("no interrupt after start");
	property p_stop_irq; en_reg && mask_reg[1] && scl_in && $rose(sda_in)
		|-> ##[2:8] irq; endproperty
	a_stop_irq: assert property (p_stop_irq)
		else $error("no interrupt after stop");
endmodule // i2c_fw_master_chk
bind i2c_fw_master i2c_fw_master_chk chk_u (.sys_clk(sys_clk), .nrst(nrst),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_in(scl_in),
	.sda_in(sda_in), .scl_out(scl_out), .sda_out(sda_out),
	.scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n), .irq(irq));
`default_nettype wire

//--- sim/test_i2c_fw_master.sv
// Bench for firmware master support: registers, pins and conditions
`default_nettype none
module test_i2c_fw_master;
	timeunit 1ns;
	timeprecision 100ps;
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic scl_out, sda_out, scl_oe_n, sda_oe_n, irq;
	logic scl_pull, sda_pull, scl_line, sda_line, ack;
	int miscompares = 0;
	int total_checks = 0;
	// Pull-ups win unless some party pulls the line low
	assign scl_line = !scl_pull && (scl_oe_n || scl_out);
	assign sda_line = !sda_pull && (sda_oe_n || sda_out);
	always #2.5 sys_clk = ~sys_clk;
	i2c_fw_master dut_u (.sys_clk(sys_clk), .nrst(nrst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_in(scl_line),
		.sda_in(sda_line), .scl_out(scl_out), .sda_out(sda_out),
		.scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n), .irq(irq));
	i2c_bus_partner p_u (.sda_line(sda_line), .scl_pull(scl_pull),
		.sda_pull(sda_pull));
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	// Read, keep the bits of m and compare
	task automatic rc(input logic [7:0] a, input logic [7:0] e,
		input logic [7:0] m);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata & m, e);
	endtask
	// Interrupt level once settled
	task automatic irq_is(input logic e);
		repeat (3) @(posedge sys_clk);
		#1 chk({7'h0, irq}, {7'h0, e});
	endtask
	task automatic end_sim();
		$display("checks %0d, mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		rc(8'h86, 8'hff, 8'hff);
		rc(8'h94, 8'h00, 8'hff);
		rc(8'h14, 8'h00, 8'hff);
		rc(8'h0c, 8'h00, 8'hff);
		rc(8'h8c, 8'h00, 8'hff);
		rc(8'h93, 8'h00, 8'hff);
		rc(8'h55, 8'h00, 8'hff);
	endtask
	// Direction bits pull lines low whatever the latch holds
	task automatic t_dir();
		wr(8'h14, 8'h2b);
		wr(8'h06, 8'hff);
		wr(8'h86, 8'hef);
		#1 chk({6'h0, scl_line, sda_line}, 8'h01);
		wr(8'h86, 8'hfd);
		#1 chk({6'h0, scl_line, sda_line}, 8'h02);
		wr(8'h86, 8'hff);
		#1 chk({6'h0, scl_line, sda_line}, 8'h03);
		// Releasing data with the clock high is a stop; clear its event
		irq_is(1'b0);
		rc(8'h40, 8'h02, 8'h0f);
	endtask
	// Master support mode: start, byte, stop, then disable
	task automatic t_cond();
		wr(8'h94, 8'h00);
		wr(8'h93, 8'h42);
		wr(8'h0b, 8'hc0);
		p_u.start();
		irq_is(1'b0);
		rc(8'h94, 8'h08, 8'h18);
		wr(8'h8c, 8'h08);
		irq_is(1'b1);
		wr(8'h0c, 8'h00);
		irq_is(1'b0);
		rc(8'h40, 8'h01, 8'h0f);
		rc(8'h40, 8'h00, 8'h0f);
		wr(8'h41, 8'h07);
		p_u.send(8'h42, ack);
		chk({7'h0, ack}, 8'h01);
		repeat (10) @(posedge sys_clk);
		rc(8'h40, 8'h04, 8'h0f);
		rc(8'h0c, 8'h08, 8'h08);
		wr(8'h0c, 8'h00);
		irq_is(1'b0);
		p_u.stop();
		irq_is(1'b1);
		rc(8'h94, 8'h10, 8'h18);
		rc(8'h40, 8'h02, 8'h0f);
		wr(8'h14, 8'h0b);
		rc(8'h94, 8'h00, 8'h18);
	endtask
	// Slave keeps listening: foreign address refused, own one acknowledged
	task automatic t_slave();
		wr(8'h41, 8'h00);
		wr(8'h14, 8'h26);
		p_u.start();
		p_u.send(8'h44, ack);
		p_u.stop();
		chk({7'h0, ack}, 8'h01);
		p_u.start();
		p_u.send(8'h42, ack);
		p_u.stop();
		chk({7'h0, ack}, 8'h00);
		rc(8'h40, 8'h08, 8'h08);
		rc(8'h13, 8'h42, 8'hff);
	endtask
	// Master support mode with start and stop events unmasked
	task automatic t_rearm();
		wr(8'h8c, 8'h00);
		wr(8'h14, 8'h2b);
		wr(8'h41, 8'h01);
		p_u.start();
		irq_is(1'b1);
		rc(8'h40, 8'h01, 8'h0f);
		irq_is(1'b0);
		wr(8'h41, 8'h02);
		p_u.stop();
		irq_is(1'b1);
		rc(8'h40, 8'h02, 8'h0f);
	endtask
	initial begin
		repeat (5) @(posedge sys_clk);
		nrst <= 1'b1;
		t_reset();
		t_dir();
		t_cond();
		t_slave();
		t_rearm();
		end_sim();
	end
	// Watchdog
	initial begin
		#100000;
		miscompares++;
		end_sim();
	end
endmodule // test_i2c_fw_master
`default_nettype wire
